//--- hdl/qsg_pkg.sv
// Constants for the questionable-status register group.
// Assumes one clock domain; imported by the event latch, the status group and the bench, not by the interface.
package qsg_pkg;
  localparam int QSG_W = 16;                        // Register width
  localparam logic [1:0] QSG_SEL_COND = 2'h0;       // Condition query select
  localparam logic [1:0] QSG_SEL_EVENT = 2'h1;      // Event query select
  localparam logic [1:0] QSG_SEL_ENAB = 2'h2;       // Enable mask select
  localparam int QSG_BIT_BACKUP = 7;                // Backup fault position
  localparam int QSG_BIT_HWINFO = 8;                // Hardware-info fault position
  localparam logic [15:0] QSG_USED_MASK = 16'h0180; // Assigned bit positions
  localparam logic [15:0] QSG_ENAB_RESET = 16'h0000; // Mask value after power-on
  localparam logic [15:0] QSG_ZERO = 16'h0000;      // All-clear word
endpackage

//--- hdl/qsg_evt_if.sv
// Carrier between the register front end and the event latch.
// Assumes both ends share one clock.
`timescale 1ns/1ns
`default_nettype none
interface qsg_evt_if;
  logic [15:0] cond; // Live condition word
  logic clr;         // Clear-status pulse
  logic [15:0] evt;  // Latched event word
  modport front (output cond, output clr, input evt);
  modport latch (input cond, input clr, output evt);
endinterface
`default_nettype wire

//--- hdl/qsg_event_latch.sv
// Sticky event bits, one per condition bit.
// Assumes the front end gives only assigned condition bits.
`timescale 1ns/1ns
`default_nettype none
module qsg_event_latch
  import qsg_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  qsg_evt_if.latch lnk
);
  logic [15:0] evt_reg; // Latched events
  logic [15:0] evt_next; // Next latched events

  // Per-bit set/clear, set beats clear
  genvar gi;
  generate
    for (gi = 0; gi < QSG_W; gi++) begin : g_bit
      always_comb begin
        if (!QSG_USED_MASK[gi]) begin
          evt_next[gi] = 1'b0;
        end else if (lnk.cond[gi]) begin
          evt_next[gi] = 1'b1;
        end else if (lnk.clr) begin
          evt_next[gi] = 1'b0;
        end else begin
          evt_next[gi] = evt_reg[gi];
        end
      end
    end
  endgenerate

  // Register stage, frozen while ce is low
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      evt_reg <= QSG_ZERO;
    end else if (ce) begin
      evt_reg <= evt_next;
    end
  end

  assign lnk.evt = evt_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_set;
    ce && (lnk.cond != QSG_ZERO);
  endsequence
  property p_evt_sets;
    s_set |=> ((evt_reg & $past(lnk.cond)) == $past(lnk.cond));
  endproperty
  a_evt_sets: assert property (p_evt_sets) else $error("event bit not set");

  property p_evt_holds;
    ce && !lnk.clr |=> ((evt_reg & $past(evt_reg)) == $past(evt_reg));
  endproperty
  a_evt_holds: assert property (p_evt_holds) else $error("event bit lost");

  property p_evt_unused;
    (evt_reg & ~QSG_USED_MASK) == QSG_ZERO;
  endproperty
  a_evt_unused: assert property (p_evt_unused) else $error("unused event bit set");
endmodule
`default_nettype wire

//--- hdl/qsg_questionable_status.sv
// Questionable-status register group: condition, event and enable mask.
// Assumes command strobes and fault levels are synchronous to clock.
`timescale 1ns/1ns
`default_nettype none
module qsg_questionable_status
  import qsg_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic backupFault,
  input wire logic hwInfoFault,
  input wire logic clrStatus,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [1:0] cmdSel,
  input wire logic [15:0] cmdData,
  output logic rspValid,
  output logic [15:0] rspData,
  output logic quesSummary
);
  qsg_evt_if lnk (); // Link to the event latch

  logic [15:0] condWord; // Live condition word
  logic [15:0] enab_reg; // Enable mask as written
  logic [15:0] enab_next; // Next mask
  logic rspValid_reg; // Answer strobe
  logic rspValid_next; // Next answer strobe
  logic [15:0] rspData_reg; // Answer word
  logic [15:0] rspData_next; // Next answer word
  logic summary_reg; // Enabled event summary
  logic summary_next; // Next summary

  // Live fault word, unassigned positions held at zero
  always_comb begin
    condWord = QSG_ZERO;
    condWord[QSG_BIT_BACKUP] = backupFault;
    condWord[QSG_BIT_HWINFO] = hwInfoFault;
  end

  assign lnk.cond = condWord;
  assign lnk.clr = clrStatus;

  // Sticky event bits
  qsg_event_latch u_latch (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .lnk(lnk)
  );

  // Command decode and query answer
  always_comb begin
    enab_next = enab_reg;
    rspValid_next = 1'b0;
    rspData_next = rspData_reg;
    if (cmdValid && cmdWrite) begin
      // Only the mask select stores; other writes are dropped
      if (cmdSel == QSG_SEL_ENAB) begin
        enab_next = cmdData;
      end
    end else if (cmdValid) begin
      // Query: answer word and strobe one cycle later
      rspValid_next = 1'b1;
      case (cmdSel)
        QSG_SEL_COND: begin
          rspData_next = condWord;
        end
        QSG_SEL_EVENT: begin
          rspData_next = lnk.evt;
        end
        QSG_SEL_ENAB: begin
          rspData_next = enab_reg & QSG_USED_MASK;
        end
        default: begin
          rspData_next = QSG_ZERO; // Unmapped select reads zero
        end
      endcase
    end
    // Onward summary of enabled, assigned event bits
    summary_next = |(lnk.evt & enab_reg & QSG_USED_MASK);
  end

  // Register stage, frozen while ce is low
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      enab_reg <= QSG_ENAB_RESET;
      rspValid_reg <= 1'b0;
      rspData_reg <= QSG_ZERO;
      summary_reg <= 1'b0;
    end else if (ce) begin
      enab_reg <= enab_next;
      rspValid_reg <= rspValid_next;
      rspData_reg <= rspData_next;
      summary_reg <= summary_next;
    end
  end

  assign rspValid = rspValid_reg;
  assign rspData = rspData_reg;
  assign quesSummary = summary_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Query strobe for a given select
  sequence s_query(logic [1:0] sel);
    ce && cmdValid && !cmdWrite && cmdSel == sel;
  endsequence

  // Write strobe for a given select
  sequence s_write(logic [1:0] sel);
    ce && cmdValid && cmdWrite && cmdSel == sel;
  endsequence

  // Clear-status pulse taken this cycle
  sequence s_clear;
    ce && clrStatus;
  endsequence

  // Condition answer carries the live backup fault
  property p_cond_live;
    s_query(QSG_SEL_COND) |=> rspValid && rspData[QSG_BIT_BACKUP] == $past(backupFault);
  endproperty
  a_cond_live: assert property (p_cond_live) else $error("condition not live");

  // Condition answer carries the live hardware-info fault
  property p_cond_hwinfo;
    s_query(QSG_SEL_COND) |=> rspValid && rspData[QSG_BIT_HWINFO] == $past(hwInfoFault);
  endproperty
  a_cond_hwinfo: assert property (p_cond_hwinfo) else $error("hw info not live");

  // No answer ever shows an unassigned bit
  property p_unused_zero;
    rspValid |-> (rspData & ~QSG_USED_MASK) == QSG_ZERO;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit nonzero");

  // Event answer is the latched word
  property p_evt_read;
    s_query(QSG_SEL_EVENT) |=> rspData == $past(lnk.evt);
  endproperty
  a_evt_read: assert property (p_evt_read) else $error("event read wrong");

  // Hardware-info fault lands in event bit 8
  property p_hwinfo;
    ce && hwInfoFault ##1 s_query(QSG_SEL_EVENT) |=> rspData[QSG_BIT_HWINFO];
  endproperty
  a_hwinfo: assert property (p_hwinfo) else $error("hw info not in bit 8");

  // Mask stores the whole written word
  property p_mask_write;
    ce && cmdValid && cmdWrite && cmdSel == QSG_SEL_ENAB |=> enab_reg == $past(cmdData);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  // Writes to other selects leave the mask alone
  property p_write_refused;
    ce && cmdValid && cmdWrite && cmdSel != QSG_SEL_ENAB |=> $stable(enab_reg);
  endproperty
  a_write_refused: assert property (p_write_refused) else $error("write not ignored");

  // A mask write never raises the answer strobe
  property p_write_silent;
    s_write(QSG_SEL_ENAB) |=> !rspValid;
  endproperty
  a_write_silent: assert property (p_write_silent) else $error("write gave an answer");

  // Answer strobe drops when no command came
  property p_rsp_pulse;
    ce && !cmdValid |=> !rspValid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer strobe stuck");

  // Mask and summary clear on leaving reset
  property p_mask_reset;
    $rose(rst_n) |-> enab_reg == QSG_ENAB_RESET && !quesSummary;
  endproperty
  a_mask_reset: assert property (@(posedge clock) p_mask_reset)
    else $error("mask not zero at reset");

  // Mask readback hides unassigned bits
  property p_mask_read;
    s_query(QSG_SEL_ENAB) |=> rspData == ($past(enab_reg) & QSG_USED_MASK);
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask readback wrong");

  // Onward summary only from enabled assigned event bits
  property p_summary;
    ce |=> quesSummary == (($past(lnk.evt[QSG_BIT_BACKUP]) && $past(enab_reg[QSG_BIT_BACKUP]))
      || ($past(lnk.evt[QSG_BIT_HWINFO]) && $past(enab_reg[QSG_BIT_HWINFO])));
  endproperty
  a_summary: assert property (p_summary) else $error("summary wrong");

  // Event bit retained after the fault goes away
  property p_sticky;
    ce && backupFault ##1 (ce && !clrStatus)[*2] |=> lnk.evt[QSG_BIT_BACKUP];
  endproperty
  a_sticky: assert property (p_sticky) else $error("event not retained");

  // An active fault keeps its event bit through a clear
  property p_set_wins;
    s_clear ##0 backupFault |=> lnk.evt[QSG_BIT_BACKUP];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat active fault");

  // A clear with no fault empties the event word
  property p_clear;
    s_clear ##0 (!backupFault && !hwInfoFault) |=> lnk.evt == QSG_ZERO;
  endproperty
  a_clear: assert property (p_clear) else $error("event not cleared");

  // Low clock enable freezes every register
  property p_freeze;
    !ce |=> $stable(enab_reg) && $stable(rspValid) && $stable(rspData)
      && $stable(quesSummary) && $stable(lnk.evt);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with ce low");
endmodule
`default_nettype wire

//--- bench/qsg_ctrl_model.sv
// Remote controller model: issues one command per call.
// Assumes the bench calls xfer and the device answers one edge later.
`timescale 1ns/1ns
`default_nettype none
module qsg_ctrl_model (
  input wire logic clock,
  output logic cmdValid,
  output logic cmdWrite,
  output logic [1:0] cmdSel,
  output logic [15:0] cmdData,
  input wire logic rspValid,
  input wire logic [15:0] rspData
);
  // Idle command port
  initial begin
    cmdValid = 0;
    cmdWrite = 0;
    cmdSel = 0;
    cmdData = 0;
  end
  // One strobe, answer taken while it stands, then idle lines toggled
  task automatic xfer(input logic w, input logic [1:0] s, input logic [15:0] d,
      output logic ok, output logic [15:0] q);
    @(negedge clock);
    cmdValid = 1;
    cmdWrite = w;
    cmdSel = s;
    cmdData = d;
    @(negedge clock);
    ok = rspValid;
    q = rspData;
    cmdValid = 0;
    cmdWrite = ~w;
    cmdSel = ~s;
    cmdData = ~d;
  endtask
endmodule
`default_nettype wire

//--- bench/test_questionable_status_group.sv
// Bench for the questionable-status group.
// Assumes the controller model drives the command port.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a,b) begin checked++; if ((a)!==(b)) begin miscompares++; \
  $display("FAIL %0t %h vs %h", $time, a, b); end end
module test_questionable_status_group
  import qsg_pkg::*;
;
  logic clock = 0, rst_n = 0, ce = 1, backupFault = 0, hwInfoFault = 0, clrStatus = 0;
  logic cmdValid, cmdWrite, rspValid, quesSummary, ok;
  logic [1:0] cmdSel;
  logic [15:0] cmdData, rspData, q, ev;
  logic [15:0] seed = 16'he400; // Fixed seed
  int miscompares = 0, checked = 0;
  // 250 MHz clock
  always #2 clock = ~clock;
  qsg_questionable_status i_dut (.clock(clock), .rst_n(rst_n), .ce(ce),
    .backupFault(backupFault), .hwInfoFault(hwInfoFault), .clrStatus(clrStatus),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdSel(cmdSel), .cmdData(cmdData),
    .rspValid(rspValid), .rspData(rspData), .quesSummary(quesSummary));
  qsg_ctrl_model i_ctl (.clock(clock), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdSel(cmdSel), .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData));
  // Xorshift step
  function automatic logic [15:0] xs(input logic [15:0] x);
    x ^= x << 7;
    x ^= x >> 9;
    x ^= x << 8;
    return x;
  endfunction
  // Query and compare the answer
  task automatic rd(input logic [1:0] s, input logic [15:0] e);
    i_ctl.xfer(1'b0, s, QSG_ZERO, ok, q);
    `CHK(ok, 1'b1)
    `CHK(q, e)
  endtask
  // Mask write, which gives no answer
  task automatic wr(input logic [15:0] d);
    i_ctl.xfer(1'b1, QSG_SEL_ENAB, d, ok, q);
    `CHK(ok, 1'b0)
  endtask
  // Verdict
  task summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
  // Main sequence
  initial begin
    repeat (20) @(negedge clock);
    rst_n = 1;
    rd(QSG_SEL_ENAB, QSG_ENAB_RESET);
    rd(QSG_SEL_EVENT, QSG_ZERO);
    `CHK(quesSummary, 1'b0)
    wr(16'hffff);
    rd(QSG_SEL_ENAB, QSG_USED_MASK);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      wr(seed);
      rd(QSG_SEL_ENAB, seed & QSG_USED_MASK);
    end
    $display("mask test done");
    ev = QSG_ZERO;
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      backupFault = seed[QSG_BIT_BACKUP];
      hwInfoFault = seed[QSG_BIT_HWINFO];
      ev |= seed & QSG_USED_MASK;
      rd(QSG_SEL_COND, seed & QSG_USED_MASK);
      rd(QSG_SEL_EVENT, ev);
      rd(2'h3, QSG_ZERO);
    end
    backupFault = 1;
    hwInfoFault = 0;
    rd(QSG_SEL_COND, 16'h0080);
    backupFault = 0;
    rd(QSG_SEL_COND, QSG_ZERO);
    rd(QSG_SEL_EVENT, ev | 16'h0080);
    $display("event test done");
    clrStatus = 1;
    @(negedge clock);
    clrStatus = 0;
    rd(QSG_SEL_EVENT, QSG_ZERO);
    hwInfoFault = 1;
    rd(QSG_SEL_EVENT, 16'h0100);
    hwInfoFault = 0;
    rd(QSG_SEL_EVENT, 16'h0100);
    wr(16'h0100);
    repeat (2) @(negedge clock);
    `CHK(quesSummary, 1'b1)
    // Clear while a fault is active: the live bit survives
    backupFault = 1;
    clrStatus = 1;
    @(negedge clock);
    clrStatus = 0;
    backupFault = 0;
    rd(QSG_SEL_EVENT, 16'h0080);
    `CHK(quesSummary, 1'b0)
    $display("clear test done");
    // Clock enable low: no command or fault lands
    @(negedge clock);
    ce = 0;
    hwInfoFault = 1;
    wr(16'h0000);
    hwInfoFault = 0;
    ce = 1;
    rd(QSG_SEL_ENAB, 16'h0100);
    rd(QSG_SEL_EVENT, 16'h0080);
    // Writes to any other select are ignored
    for (int s = 0; s < 4; s++) begin
      if (s != QSG_SEL_ENAB) begin
        i_ctl.xfer(1'b1, s[1:0], 16'hffff, ok, q);
        `CHK(ok, 1'b0)
      end
    end
    rd(QSG_SEL_ENAB, 16'h0100);
    rd(QSG_SEL_EVENT, 16'h0080);
    wr(16'h0180);
    @(negedge clock);
    `CHK(quesSummary, 1'b1)
    // Reset in mid-run returns the power-on state
    rst_n = 0;
    repeat (2) @(negedge clock);
    rst_n = 1;
    `CHK(quesSummary, 1'b0)
    rd(QSG_SEL_ENAB, QSG_ENAB_RESET);
    rd(QSG_SEL_EVENT, QSG_ZERO);
    $display("enable and reset test done");
    summarize();
  end
endmodule
`default_nettype wire
